// File: verilog/ldn_load_address_nsp.sv
`timescale 1ns/1ps
// Overview of operation
// - load address computed, memory never touched
// - word register nonsegmented, pair when segmented
// - same address arithmetic as operand fetch
// - reserved bits of loaded pair undefined
// - base pair reserved bits ignored later
// - address load leaves all flags alone
// - opcode 34 with displacement, 15 cycles
// - opcode 74 with index word, 15 cycles
// - segment control write copies full word
// - segment control is normal-mode register fourteen when segmented
// - offset control write copies full word
// - offset control is normal-mode register fifteen
// - stack pointer alias uses offset encoding
// - short byte immediate carried in word
// - control load 7D, nibble E or F
// - control loads leave flags unchanged
module ldn_load_address_nsp
  import ldn_pkg::*;
#(
  parameter int NREG = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // instruction from fetch
  input wire logic inst_valid,
  input wire logic [15:0] inst_word,
  input wire logic [15:0] ext_word,
  // processor mode
  input wire logic seg_mode,
  input wire logic system_mode,
  // status
  output logic busy,
  output logic done,
  output logic illegal,
  // register view
  input wire logic [4:0] dbg_sel,
  output logic [15:0] dbg_data
);

  logic [15:0] gpr [NREG];
  logic [15:0] normal_stack_segment;
  logic [15:0] normal_stack_offset;
  ldn_state_t state;
  logic [4:0] cnt;
  logic accept;
  logic finish;
  logic [7:0] op_byte;
  logic [3:0] src_f;
  logic [3:0] dst_f;

  // pending writes, committed at the last execution cycle
  logic [1:0] pend_en;
  logic [3:0] pend_idx [2];
  logic [15:0] pend_data [2];
  logic [1:0] pend_mask [2];
  ldn_dest_t pend_dest [2];

  // decoder results
  logic dec_ok;
  logic [4:0] dec_cnt;
  logic [1:0] dec_en;
  logic [3:0] dec_idx [2];
  logic [15:0] dec_data [2];
  logic [1:0] dec_mask [2];
  ldn_dest_t dec_dest [2];
  logic [31:0] addr_result;
  logic [3:0] byte_reg;

  assign accept = inst_valid && !busy;
  assign finish = busy && (cnt == 5'h01);
  assign op_byte = inst_word[F_OP_MSB:F_OP_LSB];
  assign src_f = inst_word[F_SRC_MSB:F_SRC_LSB];
  assign dst_f = inst_word[F_DST_MSB:F_DST_LSB];

  // banked view: normal mode sees the normal stack copies
  function automatic logic [15:0] rd_reg(input logic [3:0] i);
    logic [15:0] v;
    v = gpr[i];
    if (!system_mode && i == REG_OFS) begin
      v = normal_stack_offset;
    end else if (!system_mode && seg_mode && i == REG_SEG) begin
      v = normal_stack_segment;
    end
    return v;
  endfunction

  function automatic ldn_dest_t dest_of(input logic [3:0] i);
    ldn_dest_t d;
    d = DEST_GPR;
    if (!system_mode && i == REG_OFS) begin
      d = DEST_NSO;
    end else if (!system_mode && seg_mode && i == REG_SEG) begin
      d = DEST_NSS;
    end
    return d;
  endfunction

  // one adder for every operand address; base pair reserved bits masked off
  function automatic logic [31:0] eff_addr(input logic [3:0] base, input logic [15:0] off);
    logic [15:0] ofs;
    logic [31:0] a;
    if (seg_mode) begin
      ofs = rd_reg({base[3:1], 1'b1}) + off;
      a = {rd_reg({base[3:1], 1'b0}) & SEG_FIELD_MASK, ofs};
    end else begin
      ofs = rd_reg(base) + off;
      a = {16'h0000, ofs};
    end
    return a;
  endfunction

  // decode; only the register file is ever a destination, never memory or flags
  always_comb begin
    dec_ok = 1'b0;
    dec_cnt = 5'(ADDR_CYCLES - 1);
    dec_en = 2'b00;
    addr_result = 32'h0000_0000;
    byte_reg = {1'b0, inst_word[F_LDB_REG_MSB - 1:F_LDB_REG_LSB]};
    for (int k = 0; k < 2; k++) begin
      dec_idx[k] = dst_f;
      dec_data[k] = 16'h0000;
      dec_mask[k] = 2'b11;
      dec_dest[k] = DEST_GPR;
    end
    if (op_byte == OP_ADDR_DISP && src_f != 4'h0) begin
      dec_ok = 1'b1;
      addr_result = eff_addr(src_f, ext_word);
    end else if (op_byte == OP_ADDR_INDEX && src_f != 4'h0 && ext_word[15:12] == 4'h0 && ext_word[7:0] == 8'h00) begin
      dec_ok = 1'b1;
      addr_result = eff_addr(src_f, rd_reg(ext_word[F_IDX_MSB:F_IDX_LSB]));
    end else if (op_byte == OP_CTL_LOAD && system_mode && (dst_f == SUB_NSS || dst_f == SUB_NSO)) begin
      dec_ok = 1'b1;
      dec_cnt = 5'(CTL_CYCLES - 1);
      dec_en = 2'b01;
      dec_data[0] = rd_reg(src_f);
      dec_dest[0] = (dst_f == SUB_NSS) ? DEST_NSS : DEST_NSO; // no seg_mode check: a misplaced segment write lands
    end else if (inst_word[15:12] == OP_BYTE_IMM) begin
      dec_ok = 1'b1;
      dec_cnt = 5'(BYTE_CYCLES - 1);
      dec_en = 2'b01;
      dec_idx[0] = byte_reg;
      dec_data[0] = {2{inst_word[F_IMM_MSB:F_IMM_LSB]}};
      dec_mask[0] = inst_word[F_LDB_REG_MSB] ? 2'b01 : 2'b10;
    end
    // address results: pair when segmented, single word otherwise
    if (dec_ok && (op_byte == OP_ADDR_DISP || op_byte == OP_ADDR_INDEX)) begin
      if (seg_mode) begin
        dec_en = 2'b11;
        dec_idx[0] = {dst_f[3:1], 1'b0};
        dec_idx[1] = {dst_f[3:1], 1'b1};
        dec_data[0] = addr_result[31:16];
        dec_data[1] = addr_result[15:0];
      end else begin
        dec_en = 2'b01;
        dec_data[0] = addr_result[15:0];
      end
      dec_dest[0] = dest_of(dec_idx[0]);
      dec_dest[1] = dest_of(dec_idx[1]);
    end
  end

  // sequencer; a fixed count keeps the documented cycle totals
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
      cnt <= 5'h00;
    end else if (clk_en) begin
      done <= 1'b0;
      illegal <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (accept && dec_ok) begin
            state <= ST_EXEC;
            busy <= 1'b1;
            cnt <= dec_cnt;
          end else if (accept) begin
            illegal <= 1'b1;
          end
        end
        ST_EXEC: begin
          cnt <= cnt - 5'h01;
          if (finish) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // latch the writes at acceptance so operands cannot drift
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pend_en <= 2'b00;
      for (int k = 0; k < 2; k++) begin
        pend_idx[k] <= 4'h0;
        pend_data[k] <= 16'h0000;
        pend_mask[k] <= 2'b00;
        pend_dest[k] <= DEST_GPR;
      end
    end else if (clk_en && accept) begin
      pend_en <= dec_ok ? dec_en : 2'b00;
      for (int k = 0; k < 2; k++) begin
        pend_idx[k] <= dec_idx[k];
        pend_data[k] <= dec_data[k];
        pend_mask[k] <= dec_mask[k];
        pend_dest[k] <= dec_dest[k];
      end
    end
  end

  // register storage; no flag word lives here so flags stay put
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      normal_stack_segment <= REG_RESET;
      normal_stack_offset <= REG_RESET;
      for (int r = 0; r < NREG; r++) begin
        gpr[r] <= REG_RESET;
      end
    end else if (clk_en && finish) begin
      for (int k = 0; k < 2; k++) begin
        if (pend_en[k]) begin
          case (pend_dest[k])
            DEST_NSS: normal_stack_segment <= pend_data[k];
            DEST_NSO: normal_stack_offset <= pend_data[k];
            default: begin
              if (pend_mask[k][1]) begin
                gpr[pend_idx[k]][15:8] <= pend_data[k][15:8];
              end
              if (pend_mask[k][0]) begin
                gpr[pend_idx[k]][7:0] <= pend_data[k][7:0];
              end
            end
          endcase
        end
      end
    end
  end

  // observation port
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dbg_data <= 16'h0000;
    end else if (clk_en) begin
      if (dbg_sel == DBG_NSS_SEL) begin
        dbg_data <= normal_stack_segment;
      end else if (dbg_sel == DBG_NSO_SEL) begin
        dbg_data <= normal_stack_offset;
      end else if (!dbg_sel[4]) begin
        dbg_data <= gpr[dbg_sel[3:0]];
      end else begin
        dbg_data <= 16'h0000;
      end
    end
  end

  // checks
  property p_disp_cycles;
    @(posedge clock iff clk_en) disable iff (sys_rst)
    (accept && op_byte == OP_ADDR_DISP && src_f != 4'h0) |=> (!done)[*8] ##7 done;
  endproperty
  a_disp_cycles: assert property (p_disp_cycles) else $error("displacement load not 15 cycles");

  property p_index_cycles;
    @(posedge clock iff clk_en) disable iff (sys_rst)
    (accept && dec_ok && op_byte == OP_ADDR_INDEX) |-> ##14 !done ##1 done;
  endproperty
  a_index_cycles: assert property (p_index_cycles) else $error("index load not 15 cycles");

  property p_word_value;
    logic [3:0] v_rd;
    logic [15:0] v_a;
    @(posedge clock iff clk_en) disable iff (sys_rst)
    (accept && op_byte == OP_ADDR_DISP && src_f != 4'h0 && !seg_mode && system_mode,
      v_rd = dst_f, v_a = gpr[src_f] + ext_word) |-> ##15 gpr[v_rd] == v_a;
  endproperty
  a_word_value: assert property (p_word_value) else $error("word address wrong");

  property p_pair_value;
    logic [3:0] v_rd;
    logic [15:0] v_o;
    logic [6:0] v_s;
    @(posedge clock iff clk_en) disable iff (sys_rst)
    (accept && op_byte == OP_ADDR_DISP && src_f != 4'h0 && seg_mode && system_mode,
      v_rd = dst_f, v_o = gpr[{src_f[3:1], 1'b1}] + ext_word, v_s = gpr[{src_f[3:1], 1'b0}][14:8])
    |-> ##15 gpr[{v_rd[3:1], 1'b1}] == v_o && gpr[{v_rd[3:1], 1'b0}][14:8] == v_s;
  endproperty
  a_pair_value: assert property (p_pair_value) else $error("segmented pair address wrong");

  property p_nss_write;
    logic [15:0] v;
    @(posedge clock iff clk_en) disable iff (sys_rst)
    (accept && system_mode && op_byte == OP_CTL_LOAD && dst_f == SUB_NSS, v = gpr[src_f])
    |-> ##7 normal_stack_segment == v && done;
  endproperty
  a_nss_write: assert property (p_nss_write) else $error("segment control write wrong");

  property p_nso_write;
    logic [15:0] v;
    @(posedge clock iff clk_en) disable iff (sys_rst)
    (accept && system_mode && op_byte == OP_CTL_LOAD && dst_f == SUB_NSO, v = gpr[src_f])
    |-> ##6 normal_stack_offset == $past(normal_stack_offset) ##1 normal_stack_offset == v;
  endproperty
  a_nso_write: assert property (p_nso_write) else $error("offset control write wrong");

  property p_byte_imm;
    logic [3:0] v_w;
    logic [15:0] v_old;
    logic v_lo;
    logic [7:0] v_d;
    @(posedge clock iff clk_en) disable iff (sys_rst)
    (accept && inst_word[15:12] == OP_BYTE_IMM, v_w = byte_reg, v_old = gpr[byte_reg],
      v_lo = inst_word[F_LDB_REG_MSB], v_d = inst_word[F_IMM_MSB:F_IMM_LSB])
    |-> ##5 (v_lo ? (gpr[v_w] == {v_old[15:8], v_d}) : (gpr[v_w] == {v_d, v_old[7:0]}));
  endproperty
  a_byte_imm: assert property (p_byte_imm) else $error("short byte immediate wrong");

  property p_bad_ctl;
    @(posedge clock iff clk_en) disable iff (sys_rst)
    (accept && op_byte == OP_CTL_LOAD && dst_f != SUB_NSS && dst_f != SUB_NSO) |=> illegal && !busy;
  endproperty
  a_bad_ctl: assert property (p_bad_ctl) else $error("unsupported control load accepted");

  c_disp: cover property (@(posedge clock iff clk_en) disable iff (sys_rst) accept && op_byte == OP_ADDR_DISP ##15 done);
  c_index_seg: cover property (@(posedge clock iff clk_en) disable iff (sys_rst)
    accept && dec_ok && op_byte == OP_ADDR_INDEX && seg_mode);
  c_nss: cover property (@(posedge clock iff clk_en) disable iff (sys_rst)
    accept && dec_ok && op_byte == OP_CTL_LOAD && dst_f == SUB_NSS);
  c_byte_imm: cover property (@(posedge clock iff clk_en) disable iff (sys_rst)
    accept && inst_word[15:12] == OP_BYTE_IMM);

endmodule

// File: common/ldn_pkg.sv
package ldn_pkg;
  // first-byte opcodes and sub-codes
  localparam logic [7:0] OP_ADDR_DISP = 8'h34;
  localparam logic [7:0] OP_ADDR_INDEX = 8'h74;
  localparam logic [7:0] OP_CTL_LOAD = 8'h7D;
  localparam logic [3:0] OP_BYTE_IMM = 4'hC;
  localparam logic [3:0] SUB_NSS = 4'hE;
  localparam logic [3:0] SUB_NSO = 4'hF;
  // field positions inside the instruction words
  localparam int F_OP_MSB = 15;
  localparam int F_OP_LSB = 8;
  localparam int F_SRC_MSB = 7;
  localparam int F_SRC_LSB = 4;
  localparam int F_DST_MSB = 3;
  localparam int F_DST_LSB = 0;
  localparam int F_LDB_REG_MSB = 11;
  localparam int F_LDB_REG_LSB = 8;
  localparam int F_IMM_MSB = 7;
  localparam int F_IMM_LSB = 0;
  localparam int F_IDX_MSB = 11;
  localparam int F_IDX_LSB = 8;
  // segment number field of a pair's high word; other bits are reserved
  localparam logic [15:0] SEG_FIELD_MASK = 16'h7F00;
  localparam logic [3:0] REG_SEG = 4'hE;
  localparam logic [3:0] REG_OFS = 4'hF;
  // execution lengths in processor cycles
  localparam int ADDR_CYCLES = 15;
  localparam int CTL_CYCLES = 7;
  localparam int BYTE_CYCLES = 5;
  // reset values and register view selects
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [4:0] DBG_NSS_SEL = 5'h10;
  localparam logic [4:0] DBG_NSO_SEL = 5'h11;

  typedef enum {ST_IDLE, ST_EXEC} ldn_state_t;
  typedef enum {DEST_GPR, DEST_NSS, DEST_NSO} ldn_dest_t;
endpackage

// File: tb/ldn_load_address_nsp_bench.sv
`timescale 1ns/1ps
module ldn_load_address_nsp_bench;
  import ldn_pkg::*;
  // design inputs, all given a value at time zero
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic inst_valid = 1'b0;
  logic [15:0] inst_word = 16'h0000;
  logic [15:0] ext_word = 16'h0000;
  logic seg_mode = 1'b0;
  logic system_mode = 1'b1;
  logic [4:0] dbg_sel = 5'h00;
  logic busy;
  logic done;
  logic illegal;
  logic [15:0] dbg_data;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_cycles = 0;

  // free-running processor clock, 8 ns period
  always #4 clock = ~clock;

  ldn_load_address_nsp #(.NREG(16)) ldn_load_address_nsp_i (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .inst_valid(inst_valid), .inst_word(inst_word), .ext_word(ext_word),
    .seg_mode(seg_mode), .system_mode(system_mode),
    .busy(busy), .done(done), .illegal(illegal),
    .dbg_sel(dbg_sel), .dbg_data(dbg_data)
  );

  // verdict and end of run, reached from the main sequence or the hang guard
  task automatic end_sim();
    $display("mismatches %0d, comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs well under 2000 cycles
  always @(posedge clock) begin
    n_cycles++;
    if (n_cycles == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // word comparison, case equality so unknowns never match
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // single-bit comparison
  task automatic cmp_bit(input logic got, input logic exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask

  // register view is registered, so read one enabled edge after selecting
  task automatic check_reg(input logic [4:0] sel, input logic [15:0] mask, input logic [15:0] exp);
    @(posedge clock);
    #1 dbg_sel = sel;
    @(posedge clock);
    #1;
    cmp_word(dbg_data & mask, exp, "register view");
  endtask

  // offer one instruction; n is the expected length, 0 means it must be refused
  task automatic exec(input logic [15:0] inst, input logic [15:0] ext, input int n);
    int cnt;
    logic saw_illegal;
    logic en_edge;
    cnt = 0;
    saw_illegal = 1'b0;
    @(posedge clock);
    #1;
    inst_valid = 1'b1;
    inst_word = inst;
    ext_word = ext;
    @(posedge clock);
    #1;
    if (n == 0) begin
      inst_valid = 1'b0;
      cmp_bit(illegal, 1'b1, "illegal pulse");
      cmp_bit(busy, 1'b0, "busy after refusal");
    end else begin
      // an undecodable word offered while busy must be ignored
      inst_word = 16'h0000;
      // only enabled edges advance the design, so only they are counted
      while (done !== 1'b1 && cnt < 40) begin
        @(posedge clock);
        en_edge = clk_en;
        #1;
        inst_valid = 1'b0;
        if (en_edge) begin
          cnt++;
        end
        if (illegal === 1'b1) begin
          saw_illegal = 1'b1;
        end
      end
      cmp_word(16'(cnt), 16'(n - 1), "execution length");
      cmp_bit(saw_illegal, 1'b0, "request taken while busy");
      cmp_bit(busy, 1'b0, "busy at completion");
    end
  endtask

  // fill a word register r (0..7) through two short byte loads
  task automatic set_word(input logic [2:0] r, input logic [15:0] v);
    exec({4'hC, 1'b0, r, v[15:8]}, 16'h0000, BYTE_CYCLES);
    exec({4'hC, 1'b1, r, v[7:0]}, 16'h0000, BYTE_CYCLES);
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    #1 sys_rst = 1'b0;
    check_reg(5'h10, 16'hFFFF, 16'h0000);
    set_word(3'h5, 16'h1234);
    set_word(3'h6, 16'h0010);
    // reserved bits of the base pair set on purpose
    set_word(3'h4, 16'h83FF);
    check_reg(5'h05, 16'hFFFF, 16'h1234);
    // nonsegmented displacement form, negative displacement
    exec(16'h3452, 16'hFFF0, ADDR_CYCLES);
    check_reg(5'h02, 16'hFFFF, 16'h1224);
    check_reg(5'h05, 16'hFFFF, 16'h1234);
    exec(16'h7457, 16'h0600, ADDR_CYCLES);
    check_reg(5'h07, 16'hFFFF, 16'h1244);
    exec(16'h7457, 16'h0601, 0);
    exec(16'h3402, 16'h0000, 0);
    check_reg(5'h07, 16'hFFFF, 16'h1244);
    // segmented: pair destination, base pair reserved bits ignored
    seg_mode = 1'b1;
    exec(16'h3442, 16'h0008, ADDR_CYCLES);
    check_reg(5'h02, SEG_FIELD_MASK, 16'h0300);
    check_reg(5'h03, 16'hFFFF, 16'h123C);
    exec(16'h7440, 16'h0600, ADDR_CYCLES);
    check_reg(5'h01, 16'hFFFF, 16'h1244);
    // control loads from system mode; segment write taken in either seg_mode, done here while segmented
    exec(16'h7D3E, 16'h0000, CTL_CYCLES);
    check_reg(5'h10, 16'hFFFF, 16'h123C);
    exec(16'h7D5F, 16'h0000, CTL_CYCLES);
    check_reg(5'h11, 16'hFFFF, 16'h1234);
    exec(16'h7D5A, 16'h0000, 0);
    // normal mode: privileged load refused, R14/R15 are the stack pointer
    system_mode = 1'b0;
    exec(16'h7D3E, 16'h0000, 0);
    exec(16'h344E, 16'h0010, ADDR_CYCLES);
    check_reg(5'h10, SEG_FIELD_MASK, 16'h0300);
    check_reg(5'h11, 16'hFFFF, 16'h1244);
    // nonsegmented normal mode: R15 is the whole stack pointer
    seg_mode = 1'b0;
    exec(16'h345F, 16'h0000, ADDR_CYCLES);
    check_reg(5'h11, 16'hFFFF, 16'h1234);
    // the short stack pointer alias shares the offset encoding
    system_mode = 1'b1;
    exec(16'h7D6F, 16'h0000, CTL_CYCLES);
    check_reg(5'h11, 16'hFFFF, 16'h0010);
    // clock enable dropped mid-instruction: state freezes, length counts enabled edges
    fork
      exec(16'h3452, 16'hFFF0, ADDR_CYCLES);
      begin
        repeat (3) @(posedge clock);
        #1 clk_en = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        cmp_bit(busy, 1'b1, "busy held while frozen");
        repeat (2) @(posedge clock);
        #1 clk_en = 1'b1;
      end
    join
    check_reg(5'h02, 16'hFFFF, 16'h1224);
    end_sim();
  end
endmodule
